// [src/asp_port.sv]
// Asynchronous serial port: register file, baud timing, transmitter, receiver, auto-baud and queues.
`timescale 1ns/10ps

module asp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic                       i_clk,
	input  wire logic                       i_resetn,
	input  wire logic                       i_in_valid,
	output logic                            o_in_ready,
	input  wire logic [WIDTH-1:0]           i_in_data,
	output logic                            o_out_valid,
	input  wire logic                       i_out_ready,
	output logic [WIDTH-1:0]                o_out_data,
	output logic [$clog2(DEPTH+1)-1:0]      o_level
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int LW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [LW-1:0]    level_q;
	logic             push;
	logic             pop;

	assign o_in_ready  = (level_q != LW'(DEPTH));
	assign o_out_valid = (level_q != '0);
	assign o_out_data  = mem_q[rd_q];
	assign o_level     = level_q;
	assign push        = i_in_valid && o_in_ready;
	assign pop         = i_out_ready && o_out_valid;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_q    <= '0;
			rd_q    <= '0;
			level_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			level_q <= level_q + LW'(push) - LW'(pop);
		end
	end
endmodule

module asp_port #(
	parameter int Q_DEPTH = asp_pkg::QUEUE_DEPTH
) (
	input  wire logic                i_clk,
	input  wire logic                i_resetn,
	input  wire asp_pkg::asp_bus_type i_bus,
	output logic [15:0]              o_rdata,
	input  wire logic                i_serial_in_pin,
	output logic                     o_serial_out_pin,
	output logic                     o_tx_request,
	output logic                     o_rx_request
);
	import asp_pkg::*;
	localparam int LW = $clog2(Q_DEPTH + 1);

	asp_frame_type cfg_q;
	logic [7:0]    ctl1_q;
	logic [15:0]   div_q;
	logic [1:0]    ie_q;
	logic          q_en_q;
	logic [7:0]    prio_q;
	asp_err_type   err_q;
	logic          wake_q;
	logic          ovf_q;
	logic [15:0]   rdata_q;
	logic [7:0]    rd_byte;
	logic          wr_ok;
	logic          flag_clr;
	logic [19:0]   bit_period;
	logic [16:0]   div_plus1;

	logic          tx_in_ready, tx_out_valid, tx_pop, tx_push, tx_accept;
	logic [7:0]    tx_out_data;
	logic [LW-1:0] tx_level;
	logic          tx_busy_q, tx_line_q;
	logic [23:0]   tx_frame_q, tx_frame_d;
	logic [4:0]    tx_left_q, tx_len_d;
	logic [19:0]   tx_cnt_q;
	logic [12:0]   tx_core;
	logic [7:0]    tx_mask;
	logic [3:0]    tx_p;
	logic          tx_gap;

	logic          rx_in_ready, rx_out_valid, rx_pop, rx_push, rx_room;
	logic [7:0]    rx_out_data;
	logic [LW-1:0] rx_level;
	logic          line_q, rx_busy_q, rx_idle_q, idle_seen;
	logic [19:0]   rx_cnt_q;
	logic [3:0]    rx_idx_q, rx_p;
	logic [12:0]   rx_sh_q;
	logic [23:0]   idle_cnt_q;
	logic [7:0]    rx_data;
	logic          rx_done, rx_addr_bit, rx_par_bad, rx_brk, rx_addr_char, rx_deliver;

	logic          ab_arm_q, ab_meas_q, ab_done_q, ab_finish;
	logic          rd_byte_err;
	logic [19:0]   ab_cnt_q;

	// The host side keeps to sixteen-bit transfers, so one strobe is one register access.
	assign wr_ok     = i_bus.wr;
	assign flag_clr  = wr_ok && (i_bus.addr == ADDR_CONTROL_ONE) && i_bus.wdata[CTL1_CLR_FLAG];
	assign div_plus1 = {1'b0, div_q} + 17'h0_0001;
	assign bit_period = (div_q == 16'h0000) ? ZERO_DIV_PERIOD : {div_plus1, 3'b000};

	// Only the low byte of the write data is ever stored.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_q  <= COMM_CONTROL_RST;
			ctl1_q <= BYTE_RST;
			div_q  <= {BYTE_RST, BYTE_RST};
			ie_q   <= 2'b00;
			q_en_q <= 1'b0;
			prio_q <= BYTE_RST;
		end else begin
			if (wr_ok && i_bus.addr == ADDR_COMM_CONTROL) begin
				cfg_q <= i_bus.wdata[7:0];
			end else if (wr_ok && i_bus.addr == ADDR_CONTROL_ONE) begin
				ctl1_q <= {4'h0, i_bus.wdata[3:0]};
			end else if (wr_ok && i_bus.addr == ADDR_DIVISOR_HIGH) begin
				div_q[15:8] <= i_bus.wdata[7:0];
			end else if (wr_ok && i_bus.addr == ADDR_DIVISOR_LOW) begin
				div_q[7:0] <= i_bus.wdata[7:0];
			end else if (wr_ok && i_bus.addr == ADDR_CONTROL_TWO) begin
				ie_q <= i_bus.wdata[CTL2_RX_IE:CTL2_TX_IE];
			end else if (wr_ok && i_bus.addr == ADDR_QUEUE_TX) begin
				q_en_q <= i_bus.wdata[QTX_ENABLE];
			end else if (wr_ok && i_bus.addr == ADDR_DEBUG_PRIO) begin
				prio_q <= i_bus.wdata[7:0];
			end
			// An address-bit or idle-gap request applies to one character only.
			if (tx_pop) begin
				ctl1_q[CTL1_TX_WAKE] <= 1'b0;
			end
			if (ab_finish) begin
				div_q <= (ab_cnt_q[18:3] == 16'h0000) ? 16'h0000 : ab_cnt_q[18:3] - 16'h0001;
			end
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (i_bus.addr == ADDR_COMM_CONTROL) begin
			rd_byte = cfg_q;
		end else if (i_bus.addr == ADDR_CONTROL_ONE) begin
			rd_byte = ctl1_q;
		end else if (i_bus.addr == ADDR_DIVISOR_HIGH) begin
			rd_byte = div_q[15:8];
		end else if (i_bus.addr == ADDR_DIVISOR_LOW) begin
			rd_byte = div_q[7:0];
		end else if (i_bus.addr == ADDR_CONTROL_TWO) begin
			rd_byte = {tx_accept, !tx_busy_q, 4'h0, ie_q};
		end else if (i_bus.addr == ADDR_RX_STATE) begin
			rd_byte = {|err_q, rx_out_valid, err_q.brk, err_q.fe, err_q.oe, err_q.pe, wake_q, 1'b0};
		end else if (i_bus.addr == ADDR_RX_PEEK || i_bus.addr == ADDR_RX_BUFFER) begin
			rd_byte = rx_out_data;
		end else if (i_bus.addr == ADDR_QUEUE_TX) begin
			rd_byte = {1'b0, q_en_q, 6'(tx_level)};
		end else if (i_bus.addr == ADDR_QUEUE_RX) begin
			rd_byte = {ovf_q, 1'b0, 6'(rx_level)};
		end else if (i_bus.addr == ADDR_QUEUE_GEN) begin
			rd_byte = {ab_arm_q, ab_done_q, 6'h00};
		end else if (i_bus.addr == ADDR_DEBUG_PRIO) begin
			rd_byte = prio_q;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_q <= 16'h0000;
		end else if (i_bus.rd) begin
			rdata_q <= {8'h00, rd_byte};
		end
	end
	assign o_rdata = rdata_q;

	// Without the queue enabled the queue stands in as a single buffer register.
	assign tx_accept = q_en_q ? tx_in_ready : (tx_level == '0);
	assign tx_push   = wr_ok && (i_bus.addr == ADDR_TX_BUFFER) && tx_accept;
	assign tx_pop    = !tx_busy_q && ctl1_q[CTL1_TX_EN] && tx_out_valid;
	assign rx_room   = q_en_q ? rx_in_ready : (rx_level == '0);
	assign rx_push   = rx_deliver && rx_room;
	assign rx_pop    = i_bus.rd && (i_bus.addr == ADDR_RX_BUFFER);

	asp_fifo #(.WIDTH(8), .DEPTH(Q_DEPTH)) u_tx_queue (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_in_valid  (tx_push),
		.o_in_ready  (tx_in_ready),
		.i_in_data   (i_bus.wdata[7:0]),
		.o_out_valid (tx_out_valid),
		.i_out_ready (tx_pop),
		.o_out_data  (tx_out_data),
		.o_level     (tx_level)
	);

	asp_fifo #(.WIDTH(8), .DEPTH(Q_DEPTH)) u_rx_queue (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_in_valid  (rx_push),
		.o_in_ready  (rx_in_ready),
		.i_in_data   (rx_data),
		.o_out_valid (rx_out_valid),
		.i_out_ready (rx_pop),
		.o_out_data  (rx_out_data),
		.o_level     (rx_level)
	);

	// The whole frame is built at load time so the shifter only walks bits out.
	always_comb begin
		tx_mask = 8'hff >> (3'h7 - cfg_q.len_m1);
		tx_core = 13'h1fff;
		tx_core[0] = 1'b0;
		for (int k = 0; k < 8; k++) begin
			if (3'(k) <= cfg_q.len_m1) begin
				tx_core[k + 1] = tx_out_data[k];
			end
		end
		tx_p = {1'b0, cfg_q.len_m1} + 4'h2;
		if (cfg_q.wake_addr) begin
			tx_core[tx_p] = ctl1_q[CTL1_TX_WAKE];
			tx_p = tx_p + 4'h1;
		end
		if (cfg_q.par_en) begin
			tx_core[tx_p] = (^(tx_out_data & tx_mask)) ^ ~cfg_q.even;
		end
		tx_gap = !cfg_q.wake_addr && ctl1_q[CTL1_TX_WAKE];
		tx_frame_d = tx_gap ? {tx_core, 11'h7ff} : {11'h7ff, tx_core};
		tx_len_d = {1'b0, asp_frame_bits(cfg_q)} + {4'h0, cfg_q.stop2} + (tx_gap ? TX_GAP_BITS : 5'h00);
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_busy_q  <= 1'b0;
			tx_line_q  <= 1'b1;
			tx_frame_q <= '1;
			tx_left_q  <= 5'h00;
			tx_cnt_q   <= 20'h0_0000;
		end else if (!tx_busy_q) begin
			tx_line_q <= 1'b1;
			if (tx_pop) begin
				tx_busy_q  <= 1'b1;
				tx_frame_q <= tx_frame_d;
				tx_left_q  <= tx_len_d;
				tx_line_q  <= tx_frame_d[0];
				tx_cnt_q   <= bit_period - 20'h0_0001;
			end
		end else if (tx_cnt_q != 20'h0_0000) begin
			tx_cnt_q <= tx_cnt_q - 20'h0_0001;
		end else if (tx_left_q == 5'h01) begin
			tx_busy_q <= 1'b0;
			tx_line_q <= 1'b1;
		end else begin
			tx_frame_q <= {1'b1, tx_frame_q[23:1]};
			tx_line_q  <= tx_frame_q[1];
			tx_left_q  <= tx_left_q - 5'h01;
			tx_cnt_q   <= bit_period - 20'h0_0001;
		end
	end
	assign o_serial_out_pin = tx_line_q;

	// Idle-line detection counts clocks of high line against ten bit times.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			idle_cnt_q <= 24'h00_0000;
		end else if (!i_serial_in_pin || rx_busy_q) begin
			idle_cnt_q <= 24'h00_0000;
		end else if (!idle_seen) begin
			idle_cnt_q <= idle_cnt_q + 24'h00_0001;
		end
	end
	assign idle_seen = (idle_cnt_q >= 24'(bit_period) * IDLE_DETECT_BITS);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			line_q    <= 1'b1;
			rx_busy_q <= 1'b0;
			rx_idle_q <= 1'b0;
			rx_cnt_q  <= 20'h0_0000;
			rx_idx_q  <= 4'h0;
			rx_sh_q   <= 13'h0000;
		end else begin
			line_q <= i_serial_in_pin;
			if (!rx_busy_q) begin
				if (ctl1_q[CTL1_RX_EN] && line_q && !i_serial_in_pin) begin
					rx_busy_q <= 1'b1;
					rx_idle_q <= idle_seen;
					rx_cnt_q  <= bit_period >> 1;
					rx_idx_q  <= 4'h0;
				end
			end else if (rx_cnt_q != 20'h0_0000) begin
				rx_cnt_q <= rx_cnt_q - 20'h0_0001;
			end else begin
				rx_sh_q[rx_idx_q] <= i_serial_in_pin;
				if ((rx_idx_q == 4'h0 && i_serial_in_pin) || rx_done) begin
					rx_busy_q <= 1'b0;
				end else begin
					rx_idx_q <= rx_idx_q + 4'h1;
					rx_cnt_q <= bit_period - 20'h0_0001;
				end
			end
		end
	end

	// The first stop bit is the sample being taken in the cycle of completion.
	assign rx_done = rx_busy_q && (rx_cnt_q == 20'h0_0000) && (rx_idx_q == asp_frame_bits(cfg_q) - 4'h1);
	always_comb begin
		rx_data = 8'h00;
		for (int k = 0; k < 8; k++) begin
			if (3'(k) <= cfg_q.len_m1) begin
				rx_data[k] = rx_sh_q[k + 1];
			end
		end
		rx_p = {1'b0, cfg_q.len_m1} + 4'h2;
		rx_addr_bit = cfg_q.wake_addr && rx_sh_q[rx_p];
		rx_p = rx_p + {3'h0, cfg_q.wake_addr};
		rx_par_bad = cfg_q.par_en && (rx_sh_q[rx_p] != ((^rx_data) ^ ~cfg_q.even));
		rx_brk = !i_serial_in_pin && ((rx_sh_q & ((13'h0001 << rx_idx_q) - 13'h0001)) == 13'h0000);
		rx_addr_char = cfg_q.wake_addr ? rx_addr_bit : rx_idle_q;
		rx_deliver = rx_done && (!ctl1_q[CTL1_SLEEP] || rx_addr_char);
	end

	// A new error in the cycle of a clear stays set.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			err_q  <= '0;
			wake_q <= 1'b0;
			ovf_q  <= 1'b0;
		end else begin
			err_q.pe  <= (err_q.pe && !flag_clr) || (rx_done && rx_par_bad);
			err_q.fe  <= (err_q.fe && !flag_clr) || (rx_done && !i_serial_in_pin);
			err_q.brk <= (err_q.brk && !flag_clr) || (rx_done && rx_brk);
			err_q.oe  <= (err_q.oe && !flag_clr) || (rx_deliver && !rx_room);
			ovf_q     <= (ovf_q && !flag_clr) || (rx_deliver && !rx_room && q_en_q);
			wake_q    <= (wake_q && !flag_clr) || (rx_done && rx_addr_char);
		end
	end

	// Break has no enable of its own and rides on the receive request.
	assign o_tx_request = ie_q[CTL2_TX_IE] && tx_accept;
	assign o_rx_request = (ie_q[CTL2_RX_IE] && rx_out_valid) || err_q.brk;

	// Auto-baud times the first low pulse after arming; software sends a character with bit 0 high.
	assign ab_finish = ab_meas_q && i_serial_in_pin;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ab_arm_q  <= 1'b0;
			ab_meas_q <= 1'b0;
			ab_done_q <= 1'b0;
			ab_cnt_q  <= 20'h0_0000;
		end else if (wr_ok && i_bus.addr == ADDR_QUEUE_GEN && i_bus.wdata[QGEN_AB_ARM]) begin
			ab_arm_q  <= 1'b1;
			ab_meas_q <= 1'b0;
			ab_done_q <= 1'b0;
		end else if (ab_finish) begin
			ab_arm_q  <= 1'b0;
			ab_meas_q <= 1'b0;
			ab_done_q <= 1'b1;
		end else if (ab_meas_q) begin
			ab_cnt_q <= (ab_cnt_q == 20'hf_ffff) ? ab_cnt_q : ab_cnt_q + 20'h0_0001;
		end else if (ab_arm_q && line_q && !i_serial_in_pin) begin
			ab_meas_q <= 1'b1;
			ab_cnt_q  <= 20'h0_0001;
		end
	end

	property p_low_held;
		@(posedge i_clk) disable iff (!i_resetn) $fell(o_serial_out_pin) |-> !o_serial_out_pin [*8];
	endproperty
	a_low_held: assert property (p_low_held) else $error("line low shorter than a bit");
	property p_idle_high;
		@(posedge i_clk) disable iff (!i_resetn) !tx_busy_q |-> o_serial_out_pin;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle line not high");
	property p_full_refused;
		@(posedge i_clk) disable iff (!i_resetn)
			(wr_ok && i_bus.addr == ADDR_TX_BUFFER && !tx_accept && !tx_pop) |=> $stable(tx_level);
	endproperty
	a_full_refused: assert property (p_full_refused) else $error("write taken while buffer busy");
	// An idle-gap frame opens with high bits, so only plain frames start low at once.
	property p_tx_start;
		@(posedge i_clk) disable iff (!i_resetn) (tx_pop && !tx_gap) |=> tx_busy_q && !o_serial_out_pin;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("start bit not low after load");
	property p_tx_load;
		@(posedge i_clk) disable iff (!i_resetn) tx_pop |=> tx_busy_q && (tx_line_q == tx_frame_q[0]);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("shifter not loaded from buffer");
	property p_upper_zero;
		@(posedge i_clk) disable iff (!i_resetn) o_rdata[15:8] == 8'h00;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read byte not zero");
	property p_lane_ignored;
		@(posedge i_clk) disable iff (!i_resetn)
			(wr_ok && i_bus.addr == ADDR_COMM_CONTROL && i_bus.wdata[7:0] == cfg_q) |=> $stable(cfg_q);
	endproperty
	a_lane_ignored: assert property (p_lane_ignored) else $error("upper lane changed a register");
	property p_rx_ready;
		@(posedge i_clk) disable iff (!i_resetn) rx_push |=> rx_out_valid;
	endproperty
	a_rx_ready: assert property (p_rx_ready) else $error("character not available");
	property p_overrun;
		@(posedge i_clk) disable iff (!i_resetn) (rx_deliver && !rx_room) |=> err_q.oe && rd_byte_err;
	endproperty
	assign rd_byte_err = |err_q;
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");
	property p_tx_disabled;
		@(posedge i_clk) disable iff (!i_resetn) (!ctl1_q[CTL1_TX_EN] && !tx_busy_q) |=> !tx_busy_q;
	endproperty
	a_tx_disabled: assert property (p_tx_disabled) else $error("disabled transmitter started");
	property p_zero_div;
		@(posedge i_clk) disable iff (!i_resetn) (div_q == 16'h0000 && tx_pop) |=> tx_cnt_q == 20'h0_000f;
	endproperty
	a_zero_div: assert property (p_zero_div) else $error("zero divisor bit time wrong");
	c_tx_frame: cover property (@(posedge i_clk) disable iff (!i_resetn) $fell(tx_busy_q));
	c_rx_char: cover property (@(posedge i_clk) disable iff (!i_resetn) rx_push);
	c_overrun: cover property (@(posedge i_clk) disable iff (!i_resetn) rx_deliver && !rx_room);
	c_autobaud: cover property (@(posedge i_clk) disable iff (!i_resetn) ab_finish);
endmodule

// [src/asp_pkg.sv]
// Shared constants, register map and carrier types of the asynchronous serial port.
package asp_pkg;
	localparam logic [15:0] ADDR_COMM_CONTROL = 16'h7050;
	localparam logic [15:0] ADDR_CONTROL_ONE  = 16'h7051;
	localparam logic [15:0] ADDR_DIVISOR_HIGH = 16'h7052;
	localparam logic [15:0] ADDR_DIVISOR_LOW  = 16'h7053;
	localparam logic [15:0] ADDR_CONTROL_TWO  = 16'h7054;
	localparam logic [15:0] ADDR_RX_STATE     = 16'h7055;
	localparam logic [15:0] ADDR_RX_PEEK      = 16'h7056;
	localparam logic [15:0] ADDR_RX_BUFFER    = 16'h7057;
	localparam logic [15:0] ADDR_TX_BUFFER    = 16'h7059;
	localparam logic [15:0] ADDR_QUEUE_TX     = 16'h705a;
	localparam logic [15:0] ADDR_QUEUE_RX     = 16'h705b;
	localparam logic [15:0] ADDR_QUEUE_GEN    = 16'h705c;
	localparam logic [15:0] ADDR_DEBUG_PRIO   = 16'h705f;

	localparam int CTL1_RX_EN    = 0;
	localparam int CTL1_TX_EN    = 1;
	localparam int CTL1_SLEEP    = 2;
	localparam int CTL1_TX_WAKE  = 3;
	localparam int CTL1_CLR_FLAG = 5;
	localparam int CTL2_TX_IE    = 0;
	localparam int CTL2_RX_IE    = 1;
	localparam int CTL2_TX_EMPTY = 6;
	localparam int CTL2_TX_READY = 7;
	localparam int ST_WAKE       = 1;
	localparam int ST_RX_READY   = 6;
	localparam int ST_RX_ERROR   = 7;
	localparam int QTX_ENABLE    = 6;
	localparam int QRX_OVERFLOW  = 7;
	localparam int QGEN_AB_DONE  = 6;
	localparam int QGEN_AB_ARM   = 7;

	localparam logic [7:0]  COMM_CONTROL_RST = 8'h07;
	localparam logic [7:0]  BYTE_RST         = 8'h00;
	localparam logic [19:0] ZERO_DIV_PERIOD  = 20'h0_0010;
	localparam int          DIV_SHIFT        = 3;
	localparam logic [4:0]  TX_GAP_BITS      = 5'h0b;
	localparam logic [23:0] IDLE_DETECT_BITS = 24'h00_000a;
	localparam int          QUEUE_DEPTH      = 4;

	typedef struct packed {
		logic       stop2;
		logic       even;
		logic       par_en;
		logic       spare;
		logic       wake_addr;
		logic [2:0] len_m1;
	} asp_frame_type;

	typedef struct packed {
		logic brk;
		logic fe;
		logic oe;
		logic pe;
	} asp_err_type;

	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} asp_bus_type;

	// Bits of one frame from start through the first stop bit.
	function automatic logic [3:0] asp_frame_bits(asp_frame_type c);
		return 4'h3 + {1'b0, c.len_m1} + {3'h0, c.wake_addr} + {3'h0, c.par_en};
	endfunction
endpackage

// [src/asp_port_unused.sv]
`timescale 1ns/10ps

// [tb/asp_peer.sv]
// Remote serial peer model that sends and receives framed characters.
`timescale 1ns/10ps
module asp_peer #(
	parameter int BIT_CLKS = 24
) (
	input  wire logic i_clk,
	input  wire logic i_line,
	output logic      o_line
);
	logic [7:0] got;
	logic       ok;
	initial o_line = 1'b1;
	// Sends start, eight data bits, an optional parity bit and one stop bit of the given level.
	task automatic send(input logic [7:0] d, input logic has_par, input logic par, input logic stop);
		logic [10:0] fr;
		fr = has_par ? {1'b1, stop, par, d, 1'b0} : {1'b1, 1'b1, stop, d, 1'b0};
		for (int i = 0; i < (has_par ? 11 : 10); i++) begin
			@(negedge i_clk);
			o_line = fr[i];
			repeat (BIT_CLKS - 1) @(negedge i_clk);
		end
		@(negedge i_clk);
		o_line = 1'b1;
		// Two idle bit times let the receiver finish before the caller looks at status.
		repeat (2 * BIT_CLKS) @(negedge i_clk);
	endtask
	// Samples on the falling clock edge so the registered line is never read in its launch step.
	task automatic recv();
		ok = 1'b0;
		for (int t = 0; t < 4000 && !ok; t++) begin
			@(negedge i_clk);
			ok = !i_line;
		end
		repeat (BIT_CLKS / 2) @(negedge i_clk);
		ok = ok && !i_line;
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(negedge i_clk);
			got[i] = i_line;
		end
		repeat (BIT_CLKS) @(negedge i_clk);
		ok = ok && i_line;
	endtask
endmodule

// [tb/tb_async_serial_port.sv]
// Self-checking bench of the serial port against the remote peer model.
`timescale 1ns/10ps
module tb_async_serial_port;
	import asp_pkg::*;
	localparam int BIT_CLKS = 24;
	logic        i_clk;
	logic        i_resetn;
	asp_bus_type bus;
	logic [15:0] rdata;
	logic        line_in;
	logic        line_out;
	logic        tx_req;
	logic        rx_req;
	int          errors;
	int          n_compared;
	logic [15:0] v;

	asp_port asp_port_inst (
		.i_clk           (i_clk),
		.i_resetn        (i_resetn),
		.i_bus           (bus),
		.o_rdata         (rdata),
		.i_serial_in_pin (line_in),
		.o_serial_out_pin(line_out),
		.o_tx_request    (tx_req),
		.o_rx_request    (rx_req)
	);
	asp_peer #(.BIT_CLKS(BIT_CLKS)) asp_peer_inst (
		.i_clk (i_clk),
		.i_line(line_out),
		.o_line(line_in)
	);

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Every bus task starts and ends just after a falling edge, so strobes never toggle twice at once.
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		bus.addr = a;
		bus.wdata = d;
		bus.wr = 1'b1;
		@(negedge i_clk);
		bus.wr = 1'b0;
		@(negedge i_clk);
	endtask
	task automatic rd(input logic [15:0] a);
		bus.addr = a;
		bus.rd = 1'b1;
		@(negedge i_clk);
		bus.rd = 1'b0;
		v = rdata;
		@(negedge i_clk);
	endtask
	task automatic take(input logic [7:0] e);
		asp_peer_inst.recv();
		if (asp_peer_inst.ok !== 1'b1) begin
			errors++;
			$display("ERROR at %0t got %h expected %h", $time, asp_peer_inst.ok, 1'b1);
			finish_test();
		end
		chk({8'h00, asp_peer_inst.got}, {8'h00, e});
	endtask

	task automatic t_regs();
		logic [15:0] e;
		for (int i = 0; i < 16; i++) begin
			e = (i == 0) ? 16'h0007 : (i == 4) ? 16'h00c0 : 16'h0000;
			rd(ADDR_COMM_CONTROL + 16'(i));
			chk(v, e);
		end
		wr(ADDR_DEBUG_PRIO, 16'hff5a);
		wr(ADDR_RX_STATE, 16'h00ff);
		rd(ADDR_DEBUG_PRIO);
		chk(v, 16'h005a);
		rd(ADDR_RX_STATE);
		chk(v, 16'h0000);
		wr(ADDR_DIVISOR_HIGH, 16'h1200);
		wr(ADDR_DIVISOR_LOW, 16'hab02);
		rd(ADDR_DIVISOR_HIGH);
		chk(v, 16'h0000);
		rd(ADDR_DIVISOR_LOW);
		chk(v, 16'h0002);
	endtask
	task automatic t_tx();
		wr(ADDR_CONTROL_TWO, 16'h0001);
		chk({15'h0000, tx_req}, 16'h0001);
		wr(ADDR_CONTROL_ONE, 16'h0002);
		chk({15'h0000, tx_req}, 16'h0001);
		fork
			begin
				take(8'ha5);
				take(8'h5a);
			end
			begin
				wr(ADDR_TX_BUFFER, 16'h00a5);
				wr(ADDR_TX_BUFFER, 16'h005a);
				rd(ADDR_CONTROL_TWO);
				chk(v, 16'h0001);
			end
		join
		repeat (2 * BIT_CLKS) @(negedge i_clk);
		rd(ADDR_CONTROL_TWO);
		chk(v, 16'h00c1);
	endtask
	task automatic t_rx();
		wr(ADDR_CONTROL_ONE, 16'h0003);
		wr(ADDR_CONTROL_TWO, 16'h0002);
		asp_peer_inst.send(8'h3c, 1'b0, 1'b0, 1'b1);
		rd(ADDR_RX_STATE);
		chk(v & 16'h00fd, 16'h0040);
		chk({15'h0000, rx_req}, 16'h0001);
		rd(ADDR_RX_PEEK);
		chk(v, 16'h003c);
		rd(ADDR_RX_BUFFER);
		chk(v, 16'h003c);
		rd(ADDR_RX_STATE);
		chk(v & 16'h00fd, 16'h0000);
	endtask
	task automatic t_err();
		wr(ADDR_COMM_CONTROL, 16'h0067);
		asp_peer_inst.send(8'h03, 1'b1, 1'b0, 1'b1);
		rd(ADDR_RX_STATE);
		chk(v & 16'h00bc, 16'h0000);
		rd(ADDR_RX_BUFFER);
		asp_peer_inst.send(8'h01, 1'b1, 1'b0, 1'b1);
		rd(ADDR_RX_STATE);
		chk(v & 16'h00bc, 16'h0084);
		rd(ADDR_RX_BUFFER);
		wr(ADDR_CONTROL_ONE, 16'h0023);
		wr(ADDR_COMM_CONTROL, 16'h0007);
		wr(ADDR_CONTROL_TWO, 16'h0000);
		asp_peer_inst.send(8'h00, 1'b0, 1'b0, 1'b0);
		rd(ADDR_RX_STATE);
		chk(v & 16'h00bc, 16'h00b0);
		chk({15'h0000, rx_req}, 16'h0001);
		rd(ADDR_RX_BUFFER);
		wr(ADDR_CONTROL_ONE, 16'h0023);
		asp_peer_inst.send(8'h11, 1'b0, 1'b0, 1'b1);
		asp_peer_inst.send(8'h22, 1'b0, 1'b0, 1'b1);
		rd(ADDR_RX_STATE);
		chk(v & 16'h00bc, 16'h0088);
	endtask
	// A start bit of one bit time at divisor two must bring the divisor back to two.
	task automatic t_baud();
		wr(ADDR_DIVISOR_LOW, 16'h0005);
		wr(ADDR_QUEUE_GEN, 16'h0080);
		rd(ADDR_QUEUE_GEN);
		chk(v, 16'h0080);
		asp_peer_inst.send(8'h55, 1'b0, 1'b0, 1'b1);
		rd(ADDR_DIVISOR_LOW);
		chk(v, 16'h0002);
		rd(ADDR_QUEUE_GEN);
		chk(v, 16'h0040);
	endtask

	initial begin
		errors = 0;
		n_compared = 0;
		v = 16'h0000;
		bus = '0;
		i_resetn = 1'b0;
		repeat (6) @(negedge i_clk);
		i_resetn = 1'b1;
		t_regs();
		t_tx();
		t_rx();
		t_err();
		t_baud();
		finish_test();
	end
endmodule
